// ===== hdl/channel_clock_divider_params.svh
// Purpose: constants of the channel clock divider
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef CHANNEL_CLOCK_DIVIDER_PARAMS_SVH
`define CHANNEL_CLOCK_DIVIDER_PARAMS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_DIVIDER_ONE_CYCLE_COUNTS 9'h093
`define IDX_DIVIDER_ONE_PHASE 9'h094
`define IDX_CHANNEL_ONE_POWER_DUTY 9'h095
`define IDX_DIVIDER_TWO_CYCLE_COUNTS 9'h096
`define IDX_DIVIDER_TWO_BYPASS_CTRL 9'h097
`define IDX_DIVIDER_TWO_SYNC_PHASE 9'h197
`define IDX_CHANNEL_TWO_POWER_DUTY 9'h198
`define IDX_DIVIDER_THREE_CYCLE_COUNTS 9'h199
`define IDX_DIVIDER_THREE_BYPASS_CTRL 9'h19a
`define IDX_CHANNEL_THREE_POWER_DUTY 9'h19b
`define IDX_DIVIDER_STATUS 9'h1f0

// ----------------------------------------
// field positions
// ----------------------------------------
`define F_LOW_MSB 7
`define F_LOW_LSB 4
`define F_HIGH_MSB 3
`define F_HIGH_LSB 0
`define F_BYPASS 7
`define F_IGNORE_SYNC 6
`define F_FORCE_HIGH 5
`define F_START_HIGH 4
`define F_PHASE_MSB 3
`define F_PHASE_LSB 0
`define F_POWER_DOWN 2
`define F_DCC_OFF 0
`define PWR_MASK 8'h05

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_DIVIDER_ONE_COUNTS 8'h33
`define RST_DIVIDER_TWO_COUNTS 8'h11
`define RST_DIVIDER_THREE_COUNTS 8'h00
`define RST_CTRL 8'h00
`define RST_POWER_DUTY 8'h00

// ----------------------------------------
// output pair numbering
// ----------------------------------------
`define CHANNEL_ONE_FIRST_PAIR 3
`define CHANNEL_TWO_FIRST_PAIR 6
`define PAIRS_PER_CHANNEL 3
`define NUM_CHANNELS 3

`endif

// ===== hdl/channel_clock_divider_pkg.sv
// Purpose: types of the channel clock divider
// Assumes: constants live in channel_clock_divider_params.svh
// Notes:   types only
package channel_clock_divider_pkg;

    // divider sequencing states
    typedef enum logic [1:0] {
        DIV_RUN = 2'b00,
        DIV_HOLD = 2'b01,
        DIV_DELAY = 2'b10
    } div_state_t;

    // per-channel settings as the divider sees them
    typedef struct packed {
        logic bypass;
        logic ignore_sync;
        logic force_high;
        logic start_high;
        logic [3:0] phase;
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic power_down;
        logic dcc_off;
    } chan_cfg_t;

endpackage

// ===== hdl/channel_clock_divider.sv
// Purpose: three output clock channel dividers with AHB-Lite register access
// Assumes: i_ref_clk is the divider input clock; i_sync_b and i_dist_in are synchronous
// Notes:   bypass output is a registered copy of i_dist_in, one cycle late
`timescale 1ns/1ps
`include "channel_clock_divider_params.svh"

// How it works
// - each divider stays low for the low-count field plus one input cycles.
// - each divider stays high for the high-count field plus one input cycles.
// - the second divider resets with both counts at 1, two cycles low and two high.
// - the third divider resets with both counts at 0, one cycle low and one high.
// - bypass set stops the divider and passes the input through; clear uses the divider.
// - ignore-sync clear obeys the chip sync signal; set disregards it.
// - with ignore-sync set the output is held static at the force level, low by default.
// - the force level has no effect while the divider is bypassed.
// - start-polarity picks whether the divided clock begins low or high.
// - each divider has a four-bit phase offset that resets to zero.
// - channel power-down puts all three output pairs of the channel in high impedance.
// - channel one acts on pairs 3 to 5 and channel two on pairs 6 to 8.
// - duty-cycle correction is on while its disable bit is clear and the channel is neither bypassed nor powered down; off when set.
module channel_clock_divider (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // chip-level sync and distribution input
    input wire logic i_sync_b,
    input wire logic i_dist_in,
    // output pairs, bit 0 is pair 3
    output logic [8:0] o_pair_clk,
    output logic [8:0] o_pair_en,
    // duty-cycle correction enables per channel
    output logic [2:0] o_dcc_on
);

    // ----------------------------------------
    // register map tables
    // ----------------------------------------
    localparam int NCH = `NUM_CHANNELS;
    localparam logic [8:0] CNT_IDX [NCH] = '{`IDX_DIVIDER_ONE_CYCLE_COUNTS,
        `IDX_DIVIDER_TWO_CYCLE_COUNTS, `IDX_DIVIDER_THREE_CYCLE_COUNTS};
    localparam logic [8:0] BYP_IDX [NCH] = '{`IDX_DIVIDER_ONE_PHASE,
        `IDX_DIVIDER_TWO_BYPASS_CTRL, `IDX_DIVIDER_THREE_BYPASS_CTRL};
    localparam logic [8:0] CTL_IDX [NCH] = '{`IDX_DIVIDER_ONE_PHASE,
        `IDX_DIVIDER_TWO_SYNC_PHASE, `IDX_DIVIDER_THREE_BYPASS_CTRL};
    localparam logic [8:0] PWR_IDX [NCH] = '{`IDX_CHANNEL_ONE_POWER_DUTY,
        `IDX_CHANNEL_TWO_POWER_DUTY, `IDX_CHANNEL_THREE_POWER_DUTY};
    localparam logic [7:0] CNT_RST [NCH] = '{`RST_DIVIDER_ONE_COUNTS,
        `RST_DIVIDER_TWO_COUNTS, `RST_DIVIDER_THREE_COUNTS};

    // ----------------------------------------
    // bus state
    // ----------------------------------------
    logic wr_pend_q;
    logic rd_pend_q;
    logic [29:0] addr_q;
    logic [7:0] counts_q [NCH];
    logic [7:0] ctrl_q [NCH];
    logic [7:0] pwr_q [NCH];
    logic sync_prev_q;
    logic [2:0] level_q;
    logic [2:0] delaying_q;
    logic [7:0] rd_d;
    logic addr_ok;
    logic [8:0] idx;
    logic xfer;
    logic release_ev;
    channel_clock_divider_pkg::chan_cfg_t cfg [NCH];

    // a transfer is taken when the bus is ready and the slot is a real one
    assign xfer = i_hsel && i_hready && i_htrans[1];
    // upper address bits must be zero so aliases do not hit the map
    assign addr_ok = (addr_q[29:9] == 21'h000000);
    assign idx = addr_q[8:0];

    // ----------------------------------------
    // ahb-lite address and data phases
    // ----------------------------------------
    // capture the address phase; reads get one wait state
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 30'h00000000;
        end
        else
        begin
            wr_pend_q <= xfer && i_hwrite;
            rd_pend_q <= xfer && !i_hwrite;
            if (xfer)
            begin
                addr_q <= i_haddr[31:2];
            end
        end
    end

    // ready drops for the read data phase only; response is always okay
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hreadyout <= !(xfer && !i_hwrite);
            o_hresp <= 1'b0;
        end
    end

    // read mux; evaluated a cycle after the address phase so a write
    // in the preceding data phase is already visible
    always_comb
    begin
        rd_d = 8'h00;
        if (addr_ok)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (idx == CNT_IDX[c])
                begin
                    rd_d = rd_d | counts_q[c];
                end
                if (idx == CTL_IDX[c])
                begin
                    rd_d = rd_d | {1'b0, ctrl_q[c][6:0]};
                end
                if (idx == BYP_IDX[c])
                begin
                    rd_d = rd_d | {ctrl_q[c][7], 7'h00};
                end
                if (idx == PWR_IDX[c])
                begin
                    rd_d = rd_d | pwr_q[c];
                end
            end
            if (idx == `IDX_DIVIDER_STATUS)
            begin
                rd_d = {2'h0, delaying_q, level_q};
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_hrdata <= 32'h00000000;
        end
        else if (rd_pend_q)
        begin
            o_hrdata <= {24'h000000, rd_d};
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // writes land in the data phase; unmapped writes are dropped
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                counts_q[c] <= CNT_RST[c];
                ctrl_q[c] <= `RST_CTRL;
                pwr_q[c] <= `RST_POWER_DUTY;
            end
        end
        else if (wr_pend_q && addr_ok)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (idx == CNT_IDX[c])
                begin
                    counts_q[c] <= i_hwdata[7:0];
                end
                if (idx == CTL_IDX[c])
                begin
                    ctrl_q[c][6:0] <= i_hwdata[6:0];
                end
                if (idx == BYP_IDX[c])
                begin
                    ctrl_q[c][7] <= i_hwdata[7];
                end
                if (idx == PWR_IDX[c])
                begin
                    pwr_q[c] <= i_hwdata[7:0] & `PWR_MASK;
                end
            end
        end
    end

    // sync release is the rising edge of the active-low chip sync
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            sync_prev_q <= 1'b1;
        end
        else
        begin
            sync_prev_q <= i_sync_b;
        end
    end

    assign release_ev = i_sync_b && !sync_prev_q;

    // ----------------------------------------
    // per-channel dividers
    // ----------------------------------------
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        channel_clock_divider_pkg::div_state_t state_q;
        logic [4:0] cnt_q;
        logic [3:0] limit;
        logic obey;
        logic static_on;
        logic out_lvl;

        // unpack register fields into the settings record
        assign cfg[c].bypass = ctrl_q[c][`F_BYPASS];
        assign cfg[c].ignore_sync = ctrl_q[c][`F_IGNORE_SYNC];
        assign cfg[c].force_high = ctrl_q[c][`F_FORCE_HIGH];
        assign cfg[c].start_high = ctrl_q[c][`F_START_HIGH];
        assign cfg[c].phase = ctrl_q[c][`F_PHASE_MSB:`F_PHASE_LSB];
        assign cfg[c].low_cnt = counts_q[c][`F_LOW_MSB:`F_LOW_LSB];
        assign cfg[c].high_cnt = counts_q[c][`F_HIGH_MSB:`F_HIGH_LSB];
        assign cfg[c].power_down = pwr_q[c][`F_POWER_DOWN];
        assign cfg[c].dcc_off = pwr_q[c][`F_DCC_OFF];

        // a phase lasts its field plus one cycles, so low plus high make the period
        assign limit = level_q[c] ? cfg[c].high_cnt : cfg[c].low_cnt;
        assign obey = !cfg[c].ignore_sync;

        // sequencer: hold during sync, wait out the phase offset, then run
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
            begin
                state_q <= channel_clock_divider_pkg::DIV_RUN;
                cnt_q <= 5'h00;
                level_q[c] <= 1'b0;
            end
            else if (cfg[c].bypass)
            begin
                // divider parked while bypassed so it restarts cleanly
                state_q <= channel_clock_divider_pkg::DIV_HOLD;
                cnt_q <= 5'h00;
                level_q[c] <= cfg[c].start_high;
            end
            else if (obey && !i_sync_b)
            begin
                state_q <= channel_clock_divider_pkg::DIV_HOLD;
                cnt_q <= 5'h00;
                level_q[c] <= cfg[c].start_high;
            end
            else
            begin
                unique case (state_q)
                    channel_clock_divider_pkg::DIV_HOLD:
                    begin
                        if (cfg[c].phase == 4'h0 || !release_ev)
                        begin
                            state_q <= channel_clock_divider_pkg::DIV_RUN;
                            cnt_q <= 5'h00;
                        end
                        else
                        begin
                            // first edge shifted by the offset in input cycles
                            state_q <= channel_clock_divider_pkg::DIV_DELAY;
                            cnt_q <= {1'b0, cfg[c].phase} - 5'h01;
                        end
                        level_q[c] <= cfg[c].start_high;
                    end
                    channel_clock_divider_pkg::DIV_DELAY:
                    begin
                        if (cnt_q == 5'h00)
                        begin
                            state_q <= channel_clock_divider_pkg::DIV_RUN;
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 5'h01;
                        end
                    end
                    channel_clock_divider_pkg::DIV_RUN:
                    begin
                        if (cnt_q[3:0] == limit)
                        begin
                            cnt_q <= 5'h00;
                            level_q[c] <= !level_q[c];
                        end
                        else
                        begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    default:
                    begin
                        state_q <= channel_clock_divider_pkg::DIV_HOLD;
                        cnt_q <= 5'h00;
                    end
                endcase
            end
        end

        // phase-offset wait is visible in the status register
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
            begin
                delaying_q[c] <= 1'b0;
            end
            else
            begin
                delaying_q[c] <= (state_q == channel_clock_divider_pkg::DIV_DELAY);
            end
        end

        // output select: bypass wins over force, force needs ignore-sync
        assign static_on = cfg[c].ignore_sync && !cfg[c].bypass;
        assign out_lvl = cfg[c].bypass ? i_dist_in :
            (static_on ? cfg[c].force_high : level_q[c]);

        // three pairs per channel; power-down releases all three to high impedance
        for (genvar p = 0; p < `PAIRS_PER_CHANNEL; p++)
        begin : g_pair
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_rst_b)
                begin
                    o_pair_clk[c * `PAIRS_PER_CHANNEL + p] <= 1'b0;
                    o_pair_en[c * `PAIRS_PER_CHANNEL + p] <= 1'b0;
                end
                else
                begin
                    o_pair_clk[c * `PAIRS_PER_CHANNEL + p] <= out_lvl && !cfg[c].power_down;
                    o_pair_en[c * `PAIRS_PER_CHANNEL + p] <= !cfg[c].power_down;
                end
            end
        end

        // correction is meaningless in bypass or power-down, so it is dropped there
        always_ff @(posedge i_ref_clk)
        begin
            if (!i_rst_b)
            begin
                o_dcc_on[c] <= 1'b0;
            end
            else
            begin
                o_dcc_on[c] <= !cfg[c].dcc_off && !cfg[c].bypass && !cfg[c].power_down;
            end
        end
    end

endmodule

// ===== tb/channel_clock_divider_chk.sv
// Purpose: port-level checks of the channel clock divider
// Assumes: byte address = 4 * index, writes finish with no wait state
// Notes:   shadows channel two registers from bus writes; pair 6 is bit 3
`timescale 1ns/1ps
`include "channel_clock_divider_params.svh"
module channel_clock_divider_chk (
    // clock, reset and bus
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // sync and clock outputs
    input wire logic i_sync_b,
    input wire logic i_dist_in,
    input wire logic [8:0] o_pair_clk,
    input wire logic [8:0] o_pair_en,
    input wire logic [2:0] o_dcc_on
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    logic wr_q, last_q, take, dirty, dcc_exp, flip;
    logic [8:0] idx_q;
    logic [7:0] cnt_q, byp_q, ctl_q, pd_q;
    logic [4:0] run_q;
    logic [1:0] tr_q;
    assign take = i_hsel && i_hready && i_htrans[1];
    assign flip = o_pair_clk[3] != last_q;
    // any write or sync activity spoils the phase lengths in flight
    assign dirty = wr_q || !i_sync_b || ctl_q[6] || byp_q[7] || pd_q[2];
    assign dcc_exp = !pd_q[0] && !pd_q[2] && !byp_q[7];
    // shadow registers land on the data-phase edge, as in the design
    always_ff @(posedge i_ref_clk)
    begin
        wr_q <= i_rst_b && take && i_hwrite;
        idx_q <= (i_haddr[31:11] == 21'h0) ? i_haddr[10:2] : 9'h1ff;
        if (!i_rst_b)
        begin
            cnt_q <= `RST_DIVIDER_TWO_COUNTS;
            byp_q <= 8'h00;
            ctl_q <= 8'h00;
            pd_q <= 8'h00;
        end
        else if (wr_q)
        begin
            if (idx_q == `IDX_DIVIDER_TWO_CYCLE_COUNTS) cnt_q <= i_hwdata[7:0];
            if (idx_q == `IDX_DIVIDER_TWO_BYPASS_CTRL) byp_q <= i_hwdata[7:0];
            if (idx_q == `IDX_DIVIDER_TWO_SYNC_PHASE) ctl_q <= i_hwdata[7:0];
            if (idx_q == `IDX_CHANNEL_TWO_POWER_DUTY) pd_q <= i_hwdata[7:0];
        end
    end
    // run length of pair 6; judged only after two clean transitions
    always_ff @(posedge i_ref_clk)
    begin
        last_q <= o_pair_clk[3];
        run_q <= (flip || !i_rst_b) ? 5'h01 : run_q + 5'h01;
        if (!i_rst_b || dirty) tr_q <= 2'h0;
        else if (flip && tr_q != 2'h3) tr_q <= tr_q + 2'h1;
    end
    sequence s_read_taken;
        take && !i_hwrite;
    endsequence
    sequence s_one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    a_read_one_wait: assert property (s_read_taken |=> s_one_wait)
        else $error("read wait state not exactly one cycle");
    a_write_no_wait: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write data phase stalled");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("error response seen");
    a_run_length: assert property (flip && tr_q >= 2'h2 |->
        run_q == (last_q ? cnt_q[3:0] : cnt_q[7:4]) + 5'h01) else $error("phase length wrong");
    a_force_level: assert property ((ctl_q[6] && !byp_q[7] && !pd_q[2] &&
        $stable({ctl_q, byp_q, pd_q}))[*3] |-> o_pair_clk[3] == ctl_q[5]) else $error("forced level wrong");
    a_bypass_copy: assert property ((byp_q[7] && !pd_q[2] &&
        $stable({byp_q, pd_q}))[*3] |-> o_pair_clk[3] == $past(i_dist_in)) else $error("bypass not a copy");
    a_sync_hold: assert property ((!i_sync_b && !ctl_q[6] && !byp_q[7] && !pd_q[2] &&
        $stable({ctl_q, byp_q, pd_q}))[*4] |-> o_pair_clk[3] == ctl_q[4]) else $error("sync hold level wrong");
    a_pd_enables: assert property (1'b1 |=> o_pair_en[5:3] == {3{!$past(pd_q[2])}})
        else $error("power-down enables wrong");
    a_dcc_enable: assert property ($past(i_rst_b) |-> o_dcc_on[1] == $past(dcc_exp))
        else $error("duty correction enable wrong");
endmodule

// ===== tb/clock_rx_model.sv
// Purpose: downstream receiver that times the phases of one output pair
// Assumes: pairs are sampled on the divider input clock
// Notes:   keeps the last complete low and high run lengths
`timescale 1ns/1ps
module clock_rx_model (
    // clock and pairs
    input wire logic i_ref_clk,
    input wire logic [8:0] i_pair_clk,
    input wire logic [3:0] i_sel,
    // measured phases
    output logic [4:0] o_low_len,
    output logic [4:0] o_high_len
);
    logic last_q;
    logic [4:0] run_q;
    // a stopped pair keeps old figures, so callers wait two full periods
    always_ff @(posedge i_ref_clk)
    begin
        last_q <= i_pair_clk[i_sel];
        run_q <= (i_pair_clk[i_sel] != last_q) ? 5'h01 : run_q + 5'h01;
        if (i_pair_clk[i_sel] != last_q && last_q) o_high_len <= run_q;
        if (i_pair_clk[i_sel] != last_q && !last_q) o_low_len <= run_q;
    end
endmodule

// ===== tb/channel_clock_divider_tb.sv
// Purpose: self-checking bench for the channel clock divider
// Assumes: one wait state on reads, none on writes
// Notes:   read results go through a queue of notes and a monitor
`timescale 1ns/1ps
`include "channel_clock_divider_params.svh"
module channel_clock_divider_tb;
    logic i_ref_clk, i_rst_b, i_hsel, i_hwrite, i_sync_b, i_dist_in, o_hreadyout, o_hresp, dp;
    logic rd_ph = 1'b0;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, v;
    logic [31:0] seed = 32'h0000b6c3;
    logic [1:0] i_htrans;
    logic [8:0] o_pair_clk, o_pair_en;
    logic [8:0] cidx[3] = '{`IDX_DIVIDER_ONE_CYCLE_COUNTS, `IDX_DIVIDER_TWO_CYCLE_COUNTS,
        `IDX_DIVIDER_THREE_CYCLE_COUNTS};
    logic [2:0] o_dcc_on;
    logic [3:0] sel;
    logic [4:0] lo_len, hi_len;
    logic [31:0] exp_q[$];
    int fail_count, n_compared, d0, n;
    channel_clock_divider i_channel_clock_divider (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_sync_b(i_sync_b), .i_dist_in(i_dist_in), .o_pair_clk(o_pair_clk),
        .o_pair_en(o_pair_en), .o_dcc_on(o_dcc_on));
    clock_rx_model i_clock_rx_model (.i_ref_clk(i_ref_clk), .i_pair_clk(o_pair_clk), .i_sel(sel),
        .o_low_len(lo_len), .o_high_len(hi_len));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic results();
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    // one single transfer; a read leaves its expected data as a note
    task automatic bus(input logic w, input logic [8:0] idx, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr <= {21'h0, idx, 2'h0};
        if (!w) exp_q.push_back({24'h0, d});
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= {24'h0, d};
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    endtask
    task automatic wait_clk(input int c);
        repeat (c) @(posedge i_ref_clk);
    endtask
    // read monitor: a finished read data phase takes the oldest note
    always @(posedge i_ref_clk)
    begin
        if (rd_ph && o_hreadyout === 1'b1) chk("hrdata", exp_q.pop_front(), o_hrdata);
        if (o_hreadyout === 1'b1) rd_ph = i_hsel && i_htrans[1] && !i_hwrite;
    end
    // random distribution input so bypass copies cannot pass by luck
    always @(posedge i_ref_clk) i_dist_in <= ^rnd();
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    // hang guard, well beyond the thousand or so cycles the run needs
    initial
    begin
        #100000;
        fail_count++;
        results();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {i_rst_b, i_hsel, i_hwrite, i_htrans, i_haddr, i_hwdata} = '0;
        i_sync_b = 1'b1;
        sel = 4'h3;
        wait_clk(4);
        i_rst_b <= 1'b1;
        bus(1'b0, `IDX_DIVIDER_TWO_CYCLE_COUNTS, 8'h11);
        bus(1'b0, `IDX_DIVIDER_THREE_CYCLE_COUNTS, 8'h00);
        bus(1'b0, `IDX_DIVIDER_ONE_PHASE, 8'h00);
        bus(1'b0, `IDX_DIVIDER_TWO_SYNC_PHASE, 8'h00);
        bus(1'b1, 9'h1ff, 8'h5a);
        bus(1'b0, 9'h1ff, 8'h00);
        wait_clk(20);
        chk("ch2 low", 5'h02, lo_len);
        chk("ch2 high", 5'h02, hi_len);
        sel <= 4'h6;
        wait_clk(20);
        chk("ch3 low", 5'h01, lo_len);
        chk("ch3 high", 5'h01, hi_len);
        for (int i = 0; i < 6; i++)
        begin
            v = rnd();
            bus(1'b1, cidx[i % 3], v[7:0]);
            bus(1'b0, cidx[i % 3], v[7:0]);
            sel <= 4'((i % 3) * 3);
            wait_clk(100);
            chk("low phase", v[7:4] + 5'h01, lo_len);
            chk("high phase", v[3:0] + 5'h01, hi_len);
        end
        bus(1'b1, `IDX_CHANNEL_ONE_POWER_DUTY, 8'h04);
        bus(1'b1, `IDX_CHANNEL_TWO_POWER_DUTY, 8'h05);
        wait_clk(3);
        chk("pair enables", 9'h1c0, o_pair_en);
        chk("pair clocks", 9'h000, o_pair_clk & 9'h03f);
        chk("dcc enables", 3'h4, o_dcc_on);
        bus(1'b1, `IDX_CHANNEL_ONE_POWER_DUTY, 8'h00);
        bus(1'b1, `IDX_CHANNEL_TWO_POWER_DUTY, 8'h01);
        wait_clk(3);
        chk("pair enables", 9'h1ff, o_pair_en);
        chk("dcc enables", 3'h5, o_dcc_on);
        bus(1'b1, `IDX_CHANNEL_TWO_POWER_DUTY, 8'h00);
        bus(1'b1, `IDX_DIVIDER_TWO_SYNC_PHASE, 8'h60);
        i_sync_b <= 1'b0;
        wait_clk(6);
        chk("forced high", 9'h038, o_pair_clk & 9'h038);
        i_sync_b <= 1'b1;
        bus(1'b1, `IDX_DIVIDER_TWO_BYPASS_CTRL, 8'h80);
        wait_clk(3);
        for (int i = 0; i < 8; i++)
        begin
            dp = i_dist_in;
            @(posedge i_ref_clk);
            chk("bypass copy", dp, o_pair_clk[3]);
        end
        bus(1'b1, `IDX_DIVIDER_TWO_BYPASS_CTRL, 8'h00);
        bus(1'b1, `IDX_DIVIDER_TWO_SYNC_PHASE, 8'h40);
        wait_clk(4);
        chk("forced low", 9'h000, o_pair_clk & 9'h038);
        bus(1'b1, `IDX_DIVIDER_TWO_SYNC_PHASE, 8'h10);
        i_sync_b <= 1'b0;
        wait_clk(6);
        chk("start high", 1'b1, o_pair_clk[3]);
        bus(1'b0, `IDX_DIVIDER_STATUS, 8'h02);
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, `IDX_DIVIDER_TWO_SYNC_PHASE, p ? 8'h05 : 8'h00);
            wait_clk(6);
            chk("start low", 1'b0, o_pair_clk[3]);
            i_sync_b <= 1'b1;
            n = 0;
            while (o_pair_clk[3] !== 1'b1 && n < 40)
            begin
                @(posedge i_ref_clk);
                n++;
            end
            if (p == 0) d0 = n;
            else chk("phase delay", d0 + 5, n);
            // back into sync hold between the two runs; the last run leaves it released
            i_sync_b <= p[0];
        end
        wait_clk(4);
        results();
    end
endmodule
bind channel_clock_divider channel_clock_divider_chk i_channel_clock_divider_chk (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_sync_b(i_sync_b), .i_dist_in(i_dist_in), .o_pair_clk(o_pair_clk), .o_pair_en(o_pair_en),
    .o_dcc_on(o_dcc_on));
